// file: cpmc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.svh"

module cpmc_top
  import cpmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Analog side
  input wire cpmc_analog_in_t analog_in,
  output logic pump_enable,
  // Interrupt
  output logic irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  cpmc_mode_t mode_reg;
  logic [15:0] settle_reg;
  logic thr_reg;
  logic pump_next;
  logic pump_settled;
  logic rdy_d_reg;
  logic ack_reg;
  logic req;
  logic wr_acc;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  cpmc_events_t events;

  // --------------------------------------------------------------------------
  // Bus handshake: one wait cycle, then acknowledge
  // --------------------------------------------------------------------------
  assign req = (read || write) && !ack_reg;
  assign wr_acc = write && ack_reg;

  // Acknowledge flag toggles waitrequest low for one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Waitrequest high by default, low in acknowledge cycle, kept in a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !req;
    end
  end

  // --------------------------------------------------------------------------
  // Control register writes
  // --------------------------------------------------------------------------
  // Mode field, low byte lane carries it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= CPMC_MODE_OFF;
    end else if (wr_acc && address == `CPMC_CTRL_ADDR && byteenable[0]) begin
      mode_reg <= cpmc_mode_t'(writedata[`CPMC_MODE_HI:`CPMC_MODE_LO]);
    end
  end

  // Settle cycle count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= `CPMC_SETTLE_RST;
    end else if (wr_acc && address == `CPMC_SETTLE_ADDR) begin
      if (byteenable[0]) begin
        settle_reg[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        settle_reg[15:8] <= writedata[15:8];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pump decision
  // --------------------------------------------------------------------------
  // Mode decode against comparator and peripheral enable
  always_comb begin
    case (mode_reg)
      CPMC_MODE_ON: pump_next = 1'b1;
      CPMC_MODE_AUTO: pump_next = !analog_in.supply_above_threshold;
      CPMC_MODE_GATED: begin
        pump_next = analog_in.converter_enable_bit
                    && !analog_in.supply_above_threshold;
      end
      CPMC_MODE_OFF: pump_next = 1'b0;
      default: pump_next = 1'b0;
    endcase
  end

  // Registered pump enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_enable <= 1'b0;
    end else begin
      pump_enable <= pump_next;
    end
  end

  // Threshold status follows the comparator in every mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_reg <= 1'b0;
    end else begin
      thr_reg <= analog_in.supply_above_threshold;
    end
  end

  // --------------------------------------------------------------------------
  // Settle tracking
  // --------------------------------------------------------------------------
  cpmc_settle u_settle (
    .clk(clk),
    .rst_n(rst_n),
    .pump_on(pump_enable),
    .analog_settled(analog_in.analog_settled),
    .settle_cycles(settle_reg),
    .pump_settled(pump_settled)
  );

  // Delayed ready for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_d_reg <= 1'b0;
    end else begin
      rdy_d_reg <= pump_settled;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  // Event pulses from pump, ready and threshold transitions
  always_comb begin
    events.pump_on = pump_next && !pump_enable;
    events.pump_off = !pump_next && pump_enable;
    events.rdy_rise = pump_settled && !rdy_d_reg;
    events.thr_change = analog_in.supply_above_threshold != thr_reg;
  end

  cpmc_irq u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .events(events),
    .stat_wr(wr_acc && address == `CPMC_IRQ_STAT_ADDR && byteenable[0]),
    .mask_wr(wr_acc && address == `CPMC_IRQ_MASK_ADDR && byteenable[0]),
    .wdata(writedata[3:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Read mux registered at the request cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if (req && read) begin
      case (address)
        `CPMC_CTRL_ADDR: begin
          readdata <= {24'h000000, mode_reg, 4'h0, thr_reg, pump_settled};
        end
        `CPMC_IRQ_STAT_ADDR: readdata <= {28'h0000000, irq_status};
        `CPMC_IRQ_MASK_ADDR: readdata <= {28'h0000000, irq_mask};
        `CPMC_SETTLE_ADDR: readdata <= {16'h0000, settle_reg};
        default: readdata <= `CPMC_UNMAPPED_DATA;
      endcase
    end
  end

endmodule // cpmc_top

`default_nettype wire

// file: cpmc_defs.svh
`ifndef CPMC_DEFS_SVH
`define CPMC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CPMC_CTRL_INDEX 8'h9A
`define CPMC_CTRL_ADDR 10'h268
`define CPMC_IRQ_STAT_ADDR 10'h000
`define CPMC_IRQ_MASK_ADDR 10'h004
`define CPMC_SETTLE_ADDR 10'h008

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CPMC_MODE_HI 7
`define CPMC_MODE_LO 6
`define CPMC_THR_BIT 1
`define CPMC_RDY_BIT 0
`define CPMC_EV_ON_BIT 0
`define CPMC_EV_OFF_BIT 1
`define CPMC_EV_RDY_BIT 2
`define CPMC_EV_THR_BIT 3

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define CPMC_MODE_RST 2'h0
`define CPMC_MASK_RST 4'h0
`define CPMC_SETTLE_RST 16'h0064
`define CPMC_UNMAPPED_DATA 32'h00000000

`endif

// file: cpmc_pkg.sv
package cpmc_pkg;
  // Pump mode selection
  typedef enum logic [1:0] {
    CPMC_MODE_OFF = 2'h0,
    CPMC_MODE_GATED = 2'h1,
    CPMC_MODE_AUTO = 2'h2,
    CPMC_MODE_ON = 2'h3
  } cpmc_mode_t;

  // Analog side inputs
  typedef struct packed {
    logic supply_above_threshold;
    logic converter_enable_bit;
    logic analog_settled;
  } cpmc_analog_in_t;

  // Event group
  typedef struct packed {
    logic thr_change;
    logic rdy_rise;
    logic pump_off;
    logic pump_on;
  } cpmc_events_t;
endpackage

// file: cpmc_settle.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.svh"

module cpmc_settle
  import cpmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pump state
  input wire logic pump_on,
  input wire logic analog_settled,
  input wire logic [15:0] settle_cycles,
  // Ready
  output logic pump_settled
);

  logic [15:0] count_reg;

  // Count cycles since pump turned on, restart when off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
    end else if (!pump_on) begin
      count_reg <= 16'h0000;
    end else if (count_reg < settle_cycles) begin // Saturate, safe if count shrinks
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Ready needs elapsed count and analog flag while pump is on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_settled <= 1'b0;
    end else begin
      pump_settled <= pump_on && (count_reg >= settle_cycles) && analog_settled;
    end
  end

endmodule // cpmc_settle

`default_nettype wire

// file: cpmc_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.svh"

module cpmc_irq
  import cpmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events and software access
  input wire cpmc_events_t events,
  input wire logic stat_wr,
  input wire logic mask_wr,
  input wire logic [3:0] wdata,
  // State
  output logic [3:0] status,
  output logic [3:0] mask,
  output logic irq
);

  // Sticky status, write one clears, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 4'h0;
    end else begin
      status <= (status & ~(stat_wr ? wdata : 4'h0)) | events;
    end
  end

  // Mask register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `CPMC_MASK_RST;
    end else if (mask_wr) begin
      mask <= wdata;
    end
  end

  // Level interrupt output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~(stat_wr ? wdata : 4'h0)) | events) & (mask_wr ? wdata : mask));
    end
  end

endmodule // cpmc_irq

`default_nettype wire

// file: cpmc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module cpmc_analog_model
  import cpmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Conditions set by the bench
  input wire logic supply_hi,
  input wire logic conv_en,
  input wire logic slow,
  // Pump side
  input wire logic pump_enable,
  output var cpmc_analog_in_t analog_in
);
  logic [3:0] cnt_reg;

  // ------
  // Pump settles a few cycles after switch on, later when slow
  // ------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= 4'h0;
    else if (!pump_enable) cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hF) cnt_reg <= cnt_reg + 4'h1;
  end

  // Comparator, converter enable and settled flag
  assign analog_in = {supply_hi, conv_en, cnt_reg >= (slow ? 4'hA : 4'h2)};
endmodule // cpmc_analog_model

`default_nettype wire

// file: cpmc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.svh"

module cpmc_assertions
  import cpmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Analog and interrupt
  input wire cpmc_analog_in_t analog_in,
  input wire logic pump_enable,
  input wire logic irq
);
  logic [1:0] mode_reg;
  logic [3:0] mask_m;
  logic hi;
  logic en;
  assign hi = analog_in.supply_above_threshold;
  assign en = analog_in.converter_enable_bit;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------
  // Mode mirror from acknowledged writes
  // ------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode_reg <= 2'h0;
    else if (write && !waitrequest && address == `CPMC_CTRL_ADDR && byteenable[0])
      mode_reg <= writedata[7:6];
  end

  // Interrupt mask mirror from acknowledged writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_m <= 4'h0;
    end else if (write && !waitrequest && address == `CPMC_IRQ_MASK_ADDR && byteenable[0]) begin
      mask_m <= writedata[3:0];
    end
  end

  sequence rd_ctrl_s;
    read && !waitrequest && address == `CPMC_CTRL_ADDR;
  endsequence
  sequence pump_idle_s;
    !pump_enable [*4];
  endsequence

  on_mode_a:
    assert property ($past(mode_reg) == 2'h3 |-> pump_enable) else $error("pump off in on mode");
  auto_mode_a:
    assert property ($past(mode_reg) == 2'h2 |-> pump_enable == !$past(hi))
    else $error("auto mode mismatch");
  auto_off_a:
    assert property ($past(mode_reg) inside {2'h1, 2'h2} && $past(hi) |-> !pump_enable)
    else $error("pump on above threshold");
  gated_mode_a:
    assert property ($past(mode_reg) == 2'h1 |-> pump_enable == ($past(en) && !$past(hi)))
    else $error("gated mode mismatch");
  gated_off_a:
    assert property ($past(mode_reg) == 2'h1 && !$past(en) |-> !pump_enable)
    else $error("pump on without converter");
  off_mode_a:
    assert property ($past(mode_reg) == 2'h0 |-> !pump_enable) else $error("pump on in off mode");
  thr_bit_a:
    assert property (rd_ctrl_s and $past(rst_n, 3) |-> readdata[1] == $past(hi, 2))
    else $error("threshold bit mismatch");
  ready_off_a:
    assert property (pump_idle_s ##1 rd_ctrl_s |-> !readdata[0]) else $error("ready while off");
  mode_read_a:
    assert property (rd_ctrl_s |-> readdata[7:2] == {mode_reg, 4'h0})
    else $error("control readback mismatch");
  wait_one_a:
    assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest ##1 waitrequest)
    else $error("bus answer timing");
  irq_masked_a:
    assert property (mask_m == 4'h0 |-> !irq) else $error("interrupt while all masked");
endmodule // cpmc_assertions

bind cpmc_top cpmc_assertions i_cpmc_assertions (.clk, .rst_n, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .analog_in, .pump_enable, .irq);

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_top
  import cpmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata, rnd;
  logic waitrequest, pump_enable, irq, p;
  logic supply_hi = 1'b0, conv_en = 1'b0, slow = 1'b0;
  logic [1:0] m;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  cpmc_analog_in_t analog_in;
  integer seed = 32'h5BBDD7DE;
  int error_cnt = 0, checked = 0, cyc = 0;

  always #25 clk = ~clk;

  cpmc_top i_cpmc_top (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .analog_in, .pump_enable, .irq);
  cpmc_analog_model i_cpmc_analog_model (.clk, .rst_n, .supply_hi, .conv_en, .slow,
    .pump_enable, .analog_in);

  // ------
  // Bus tasks
  // ------
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] k);
    exp_q.push_back({e, k});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Read results against the oldest note
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) begin
      note = exp_q.pop_front();
      `CHK("readdata", note[63:32], readdata & note[31:0])
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("pump_enable", 1'b0, pump_enable)
    rd(`CPMC_CTRL_ADDR, 32'h0, 32'hFF);
    bus(1'b1, `CPMC_SETTLE_ADDR, 32'h3, 4'hF);
    bus(1'b1, `CPMC_IRQ_MASK_ADDR, 32'hF, 4'hF);
    for (int i = 0; i < 16; i++) begin
      m = i[3:2];
      rnd = $random(seed);
      supply_hi <= i[1];
      conv_en <= i[0];
      slow <= rnd[0];
      bus(1'b1, `CPMC_CTRL_ADDR, (rnd & 32'hFFFFFF3F) | {24'h0, m, 6'h00}, 4'hF);
      repeat (16) @(posedge clk);
      p = (m == 2'h3) || (m == 2'h2 && !i[1]) || (m == 2'h1 && i[0] && !i[1]);
      `CHK("pump_enable", p, pump_enable)
      rd(`CPMC_CTRL_ADDR, {24'h0, m, 4'h0, i[1], p}, 32'hFF);
    end
    supply_hi <= 1'b0;
    bus(1'b1, `CPMC_CTRL_ADDR, 32'h40, 4'hF);
    rd(`CPMC_CTRL_ADDR, 32'h41, 32'hFF);
    repeat (16) @(posedge clk);
    conv_en <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("pump_enable", 1'b0, pump_enable)
    bus(1'b1, `CPMC_CTRL_ADDR, 32'h0, 4'hE);
    rd(`CPMC_CTRL_ADDR, 32'h40, 32'hFF);
    bus(1'b1, `CPMC_CTRL_ADDR, 32'h0, 4'hF);
    `CHK("irq", 1'b1, irq)
    rd(`CPMC_IRQ_STAT_ADDR, 32'hF, 32'hF);
    bus(1'b1, `CPMC_IRQ_STAT_ADDR, 32'hF, 4'hF);
    bus(1'b1, `CPMC_IRQ_MASK_ADDR, 32'h0, 4'hF);
    bus(1'b1, `CPMC_CTRL_ADDR, 32'hC0, 4'hF);
    repeat (16) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    rd(`CPMC_IRQ_STAT_ADDR, 32'h5, 32'hF);
    bus(1'b1, `CPMC_IRQ_MASK_ADDR, 32'h1, 4'hF);
    rd(`CPMC_IRQ_MASK_ADDR, 32'h1, 32'hF);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, `CPMC_IRQ_STAT_ADDR, 32'h1, 4'hF);
    bus(1'b1, 10'h3F0, 32'hFFFFFFFF, 4'hF);
    rd(10'h3FC, 32'h0, 32'hFFFFFFFF);
    `CHK("irq", 1'b0, irq)
    repeat (4) @(posedge clk);
    results();
  end
endmodule // tb_top

`default_nettype wire
